// ==== rtl/eirq_pkg.sv ====
// eirq_pkg: register map, field layout, reset values and codes for the external interrupt unit.
// assumes a 32-bit AXI4-Lite register bus and one word per register at four times its index.
package eirq_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LINES = 8;
  // printed register indices; byte address is four times the index
  localparam logic [7:0] IDX_NMI_SENSE = 8'h02;
  localparam logic [7:0] IDX_NMI_FLAG = 8'h03;
  localparam logic [7:0] IDX_EVT_OUT_EN = 8'h04;
  localparam logic [7:0] IDX_EN_CLEAR = 8'h08;
  localparam logic [7:0] IDX_EN_SET = 8'h0C;
  localparam logic [7:0] IDX_LINE_FLAGS = 8'h10;
  // field positions
  localparam int NMI_BIT = 0;
  localparam int SENSE_W = 3;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_SENSE = 3'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // sense codes
  typedef enum logic [2:0] {
    EIRQ_SENSE_NONE = 3'b000,
    EIRQ_SENSE_RISE = 3'b001,
    EIRQ_SENSE_FALL = 3'b010,
    EIRQ_SENSE_BOTH = 3'b011,
    EIRQ_SENSE_HIGH = 3'b100,
    EIRQ_SENSE_LOW = 3'b101
  } eirq_sense_t;
  // decoded register select
  typedef enum logic [2:0] {
    EIRQ_SEL_NONE = 3'b000,
    EIRQ_SEL_SENSE = 3'b001,
    EIRQ_SEL_NMI = 3'b010,
    EIRQ_SEL_EVOE = 3'b011,
    EIRQ_SEL_CLR = 3'b100,
    EIRQ_SEL_SET = 3'b101,
    EIRQ_SEL_FLAGS = 3'b110
  } eirq_sel_t;
endpackage

// ==== rtl/eirq_regs.sv ====
// eirq_regs: flag, enable and event-gating core of the external interrupt unit with an AXI4-Lite slave.
// assumes line detectors upstream deliver one-cycle detection pulses and the nmi pin is synchronous to aclk.
`timescale 1ns/1ps
module eirq_regs (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // pins and detectors
  input wire logic nmi_pin,
  input wire logic [7:0] line_detect,
  // interrupt and event outputs
  output logic irq,
  output logic nmi_irq,
  output logic [7:0] line_event
);
  // register state
  logic [2:0] nmi_sense_r; // nonmaskable_sense_sel
  logic nmi_flag_r; // nonmaskable_irq_flag bit
  logic [7:0] evoe_r; // line_event_out_en vector
  logic [7:0] irq_en_r; // shared enable behind clear and set
  logic [7:0] flags_r; // line_irq_flags
  logic nmi_prev_r; // last nmi pin sample for edges
  // bus state
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [7:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wstrb0_r;
  // output flops
  logic irq_r, nmi_irq_r;
  logic [7:0] line_event_r;
  // decoded write and nmi detection
  logic wr_go;
  eirq_pkg::eirq_sel_t wsel;
  logic nmi_det;
  logic wr_byte;

  // address decode shared by read and write; low two bits must be zero
  function automatic eirq_pkg::eirq_sel_t reg_sel(input logic [7:0] a);
    eirq_pkg::eirq_sel_t s;
    s = eirq_pkg::EIRQ_SEL_NONE;
    if (a[1:0] == 2'h0) begin
      if (a[7:2] == eirq_pkg::IDX_NMI_SENSE[5:0]) s = eirq_pkg::EIRQ_SEL_SENSE;
      else if (a[7:2] == eirq_pkg::IDX_NMI_FLAG[5:0]) s = eirq_pkg::EIRQ_SEL_NMI;
      else if (a[7:2] == eirq_pkg::IDX_EVT_OUT_EN[5:0]) s = eirq_pkg::EIRQ_SEL_EVOE;
      else if (a[7:2] == eirq_pkg::IDX_EN_CLEAR[5:0]) s = eirq_pkg::EIRQ_SEL_CLR;
      else if (a[7:2] == eirq_pkg::IDX_EN_SET[5:0]) s = eirq_pkg::EIRQ_SEL_SET;
      else if (a[7:2] == eirq_pkg::IDX_LINE_FLAGS[5:0]) s = eirq_pkg::EIRQ_SEL_FLAGS;
    end
    return s;
  endfunction

  // write fires once both address and data are held and no response is pending
  assign wr_go = !awready_r && !wready_r && !bvalid_r;
  assign wsel = reg_sel(awaddr_r);
  // only byte lane 0 carries register bits; other lanes are ignored
  assign wr_byte = wr_go && wstrb0_r;

  // nmi sense decode; reserved codes detect nothing
  always_comb begin
    nmi_det = 1'b0;
    unique case (nmi_sense_r)
      eirq_pkg::EIRQ_SENSE_NONE: nmi_det = 1'b0;
      eirq_pkg::EIRQ_SENSE_RISE: nmi_det = nmi_pin && !nmi_prev_r;
      eirq_pkg::EIRQ_SENSE_FALL: nmi_det = !nmi_pin && nmi_prev_r;
      eirq_pkg::EIRQ_SENSE_BOTH: nmi_det = nmi_pin ^ nmi_prev_r;
      eirq_pkg::EIRQ_SENSE_HIGH: nmi_det = nmi_pin;
      eirq_pkg::EIRQ_SENSE_LOW: nmi_det = !nmi_pin;
      default: nmi_det = 1'b0;
    endcase
  end

  // pin history for edge sensing
  always_ff @(posedge aclk) begin
    if (!aresetn) nmi_prev_r <= 1'b0;
    else nmi_prev_r <= nmi_pin;
  end

  // write address channel: take once, release after the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      awaddr_r <= eirq_pkg::RST_BYTE;
    end else if (awvalid && awready_r) begin
      awready_r <= 1'b0;
      awaddr_r <= awaddr;
    end else if (bvalid_r && bready) begin
      awready_r <= 1'b1;
    end
  end

  // write data channel: independent of the address, either may come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b1;
      wdata_r <= eirq_pkg::RST_BYTE;
      wstrb0_r <= 1'b0;
    end else if (wvalid && wready_r) begin
      wready_r <= 1'b0;
      wdata_r <= wdata[7:0]; // upper lanes hold no bits
      wstrb0_r <= wstrb[0];
    end else if (bvalid_r && bready) begin
      wready_r <= 1'b1;
    end
  end

  // write response; unmapped addresses answer slverr and change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= eirq_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= (wsel == eirq_pkg::EIRQ_SEL_NONE) ? eirq_pkg::RESP_SLVERR : eirq_pkg::RESP_OKAY;
    end else if (bvalid_r && bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // plain read-write configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_sense_r <= eirq_pkg::RST_SENSE;
      evoe_r <= eirq_pkg::RST_BYTE;
    end else if (wr_byte) begin
      if (wsel == eirq_pkg::EIRQ_SEL_SENSE) nmi_sense_r <= wdata_r[eirq_pkg::SENSE_W-1:0];
      if (wsel == eirq_pkg::EIRQ_SEL_EVOE) evoe_r <= wdata_r;
    end
  end

  // shared enable vector: clear and set are two windows onto it, no read-modify-write needed
  always_ff @(posedge aclk) begin
    if (!aresetn) irq_en_r <= eirq_pkg::RST_BYTE;
    else if (wr_byte && wsel == eirq_pkg::EIRQ_SEL_CLR) irq_en_r <= irq_en_r & ~wdata_r;
    else if (wr_byte && wsel == eirq_pkg::EIRQ_SEL_SET) irq_en_r <= irq_en_r | wdata_r;
  end

  // nmi flag: a detection in the clearing cycle wins so no event is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) nmi_flag_r <= 1'b0;
    else if (nmi_det) nmi_flag_r <= 1'b1;
    else if (wr_byte && wsel == eirq_pkg::EIRQ_SEL_NMI && wdata_r[eirq_pkg::NMI_BIT]) nmi_flag_r <= 1'b0;
  end

  // line flags: write-one-to-clear, set wins over clear per bit
  always_ff @(posedge aclk) begin
    if (!aresetn) flags_r <= eirq_pkg::RST_BYTE;
    else if (wr_byte && wsel == eirq_pkg::EIRQ_SEL_FLAGS) flags_r <= (flags_r & ~wdata_r) | line_detect;
    else flags_r <= flags_r | line_detect;
  end

  // request outputs; one cycle behind the flags so the ports come from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
      nmi_irq_r <= 1'b0;
    end else begin
      irq_r <= |(flags_r & irq_en_r);
      nmi_irq_r <= nmi_flag_r; // no enable gating
    end
  end

  // event outputs: one pulse per detection, gated by the per-line enable
  always_ff @(posedge aclk) begin
    if (!aresetn) line_event_r <= eirq_pkg::RST_BYTE;
    else line_event_r <= line_detect & evoe_r;
  end

  // read channel: one read at a time, data latched at address acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= eirq_pkg::RESP_OKAY;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= eirq_pkg::RESP_OKAY;
      rdata_r <= '0; // unused bits stay zero
      unique case (reg_sel(araddr))
        eirq_pkg::EIRQ_SEL_SENSE: rdata_r[eirq_pkg::SENSE_W-1:0] <= nmi_sense_r;
        eirq_pkg::EIRQ_SEL_NMI: rdata_r[eirq_pkg::NMI_BIT] <= nmi_flag_r;
        eirq_pkg::EIRQ_SEL_EVOE: rdata_r[7:0] <= evoe_r;
        eirq_pkg::EIRQ_SEL_CLR: rdata_r[7:0] <= irq_en_r;
        eirq_pkg::EIRQ_SEL_SET: rdata_r[7:0] <= irq_en_r;
        eirq_pkg::EIRQ_SEL_FLAGS: rdata_r[7:0] <= flags_r;
        eirq_pkg::EIRQ_SEL_NONE: rresp_r <= eirq_pkg::RESP_SLVERR;
        default: rresp_r <= eirq_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // port drive
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign irq = irq_r;
  assign nmi_irq = nmi_irq_r;
  assign line_event = line_event_r;

  // a detection always leaves the nmi flag set next cycle
  nmi_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    nmi_det |=> nmi_flag_r) else $error("nmi flag not set after detection");

  // a one written to the flag with no detection clears it
  nmi_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_byte && wsel == eirq_pkg::EIRQ_SEL_NMI && wdata_r[0] && !nmi_det) |=> !nmi_flag_r)
    else $error("nmi flag not cleared by write one");

  // bits 31:8 of every read word are zero
  rsv_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_r |-> (rdata_r[31:8] == 24'h000000)) else $error("unused read bits not zero");

  // events follow detections only on enabled lines
  event_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 line_event_r == ($past(line_detect) & $past(evoe_r))) else $error("event gating wrong");

  // clear window drops exactly the written ones
  en_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_byte && wsel == eirq_pkg::EIRQ_SEL_CLR) |=> irq_en_r == ($past(irq_en_r) & ~$past(wdata_r)))
    else $error("enable clear wrong");

  // set window adds exactly the written ones
  en_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_byte && wsel == eirq_pkg::EIRQ_SEL_SET) |=> irq_en_r == ($past(irq_en_r) | $past(wdata_r)))
    else $error("enable set wrong");

  // both windows read the shared vector
  en_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && arready_r && (reg_sel(araddr) == eirq_pkg::EIRQ_SEL_CLR || reg_sel(araddr) == eirq_pkg::EIRQ_SEL_SET))
    |=> rdata_r[7:0] == $past(irq_en_r)) else $error("enable read mismatch");

  // interrupt line tracks enabled flags one cycle late
  line_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 irq_r == $past(|(flags_r & irq_en_r))) else $error("irq does not match enabled flags");

  // rising sense catches a low to high pin step
  sense_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (nmi_sense_r == eirq_pkg::EIRQ_SENSE_RISE && $rose(nmi_pin)) |-> nmi_det) else $error("rise sense missed");

  // nmi request high once the flag has stayed set two cycles
  nmi_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    nmi_flag_r [*2] |-> nmi_irq_r) else $error("nmi request dropped while flag set");

  // a set flag raises the request at the next edge, whatever the line enables say
  nmi_req_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    nmi_flag_r |=> nmi_irq_r) else $error("nmi request not raised");
  // the request is a level, so it must also fall once the flag is gone

  // a cleared flag lets the request go one cycle later
  nmi_req_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !nmi_flag_r |=> !nmi_irq_r) else $error("nmi request held without flag");
  // without this a stuck request would still pass the hold check above

  // a zero in bit 0 never clears a set flag
  nmi_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_byte && wsel == eirq_pkg::EIRQ_SEL_NMI && !wdata_r[eirq_pkg::NMI_BIT] && nmi_flag_r) |=> nmi_flag_r)
    else $error("nmi flag lost on zero write");

  // nmi flag reads back with bits 31:1 at zero
  nmi_read_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && arready_r && reg_sel(araddr) == eirq_pkg::EIRQ_SEL_NMI) |=> (rdata_r[31:1] == 31'h00000000))
    else $error("nmi flag read has unused bits set");

  // disabled lines never emit an event
  event_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ((line_detect & ~evoe_r) != 8'h00) |=> ((line_event_r & ~$past(evoe_r)) == 8'h00))
    else $error("event on disabled line");

  // the enable vector moves only through its two windows
  en_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !(wr_byte && (wsel == eirq_pkg::EIRQ_SEL_CLR || wsel == eirq_pkg::EIRQ_SEL_SET)) |=> $stable(irq_en_r))
    else $error("enable vector changed without a write");

  // every detection leaves its flag set next cycle, masked or not
  flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (line_detect != 8'h00) |=> ((flags_r & $past(line_detect)) == $past(line_detect)))
    else $error("line flag not set by detection");

  // flags are sticky until software writes the flag register
  flag_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !(wr_byte && wsel == eirq_pkg::EIRQ_SEL_FLAGS) |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
    else $error("line flag lost without clear");

  // no detection with sense off or a reserved code
  sense_none_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (nmi_sense_r == eirq_pkg::EIRQ_SENSE_NONE || nmi_sense_r[2:1] == 2'b11) |-> !nmi_det)
    else $error("nmi detected with sense off");

  // high-level sense follows the pin level every cycle
  sense_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (nmi_sense_r == eirq_pkg::EIRQ_SENSE_HIGH) |-> (nmi_det == nmi_pin))
    else $error("high level sense wrong");
  // level senses keep setting the flag, so software must change the sense before a clear sticks
endmodule

// ==== testbench/eirq_pins.sv ====
// eirq_pins: far-side model of the pin detectors feeding the external interrupt unit.
// assumes raw pin levels come from the bench, changed just after a rising aclk edge.
`timescale 1ns/1ps
module eirq_pins (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // raw pin levels
  input wire logic [7:0] raw_lines,
  input wire logic raw_nmi,
  // toward the unit
  output logic [7:0] line_detect,
  output logic nmi_pin
);
  logic [7:0] prev_r; // last sampled line levels
  // rising-edge detector: one pulse per edge, so a held level is one detection only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 8'h00;
      line_detect <= 8'h00;
      nmi_pin <= 1'b0;
    end else begin
      line_detect <= raw_lines & ~prev_r;
      prev_r <= raw_lines;
      nmi_pin <= raw_nmi; // registered so the pin is synchronous to aclk
    end
  end
endmodule

// ==== testbench/tb_eirq_regs.sv ====
// tb_eirq_regs: self-checking bench for the external interrupt unit registers.
// assumes the unit answers on AXI4-Lite and the pin model sits between bench and unit.
`timescale 1ns/1ps
module tb_eirq_regs;
  localparam logic [7:0] A_SNS = 8'(eirq_pkg::IDX_NMI_SENSE * 4);
  localparam logic [7:0] A_NMI = 8'(eirq_pkg::IDX_NMI_FLAG * 4);
  localparam logic [7:0] A_EVO = 8'(eirq_pkg::IDX_EVT_OUT_EN * 4);
  localparam logic [7:0] A_CLR = 8'(eirq_pkg::IDX_EN_CLEAR * 4);
  localparam logic [7:0] A_SET = 8'(eirq_pkg::IDX_EN_SET * 4);
  localparam logic [7:0] A_FLG = 8'(eirq_pkg::IDX_LINE_FLAGS * 4);
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, raw_nmi = 1'b0, f;
  logic awready, wready, bvalid, arready, rvalid, irq, nmi_irq, nmi_pin;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, raw = 8'h00, m, en, line_detect, line_event;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic [1:0] bresp, rresp;
  logic [33:0] rdq[$]; // expected {rresp, rdata} per read
  logic [7:0] evq[$]; // expected event vectors
  int errors = 0, n_tests = 0, cyc = 0, code, seed = 32'h8da3;
  eirq_regs dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .nmi_pin(nmi_pin), .line_detect(line_detect),
    .irq(irq), .nmi_irq(nmi_irq), .line_event(line_event));
  eirq_pins pins (.aclk(aclk), .aresetn(aresetn), .raw_lines(raw), .raw_nmi(raw_nmi),
    .line_detect(line_detect), .nmi_pin(nmi_pin));
  // 25 MHz clock
  initial begin
    forever #20 aclk = ~aclk;
  end
  task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one compare task per kind of result, all counting through chk
  task chk_read(input logic [33:0] e, input logic [33:0] g);
    chk("rdata", e, g);
  endtask
  task chk_event(input logic [7:0] e, input logic [7:0] g);
    chk("line_event", {26'h0, e}, {26'h0, g});
  endtask
  task chk_irq(input string nm, input logic e, input logic g);
    chk(nm, {33'h0, e}, {33'h0, g});
  endtask
  task chk_resp(input logic [1:0] e, input logic [1:0] g);
    chk("bresp", {32'h0, e}, {32'h0, g});
  endtask
  task give_verdict;
    if (errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one write; address and data offered together, each released when taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        chk_resp(r, bresp);
        break;
      end
    end
    bready <= 1'b0;
  endtask
  // one read; the expectation goes to the queue for the watcher
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    rdq.push_back({r, d});
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 0;
  endtask
  // watcher: read answers and event pulses against the oldest note
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready) chk_read(rdq.pop_front(), {rresp, rdata});
    if (aresetn && line_event !== 8'h00) chk_event(evq.pop_front(), line_event);
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_NMI, 32'h0);
    rd(A_EVO, 32'h0);
    rd(A_CLR, 32'h0);
    rd(A_SET, 32'h0);
    rd(A_FLG, 32'h0);
    wr(8'h50, 32'hFFFFFFFF, 2'h2);
    rd(8'h50, 32'h0, 2'h2);
    m = 8'($random(seed)) | 8'h81; // bit 7 kept set so the mask test has a live line
    wr(A_SET, {24'hFFFFFF, m});
    rd(A_CLR, {24'h0, m});
    wr(A_CLR, 32'h0F);
    rd(A_SET, {24'h0, m & 8'hF0});
    wr(A_SET, 32'h0);
    rd(A_CLR, {24'h0, m & 8'hF0});
    en = m & 8'hF0;
    m = 8'($random(seed)) | 8'h01;
    wr(A_EVO, {24'hFFFFFF, m});
    rd(A_EVO, {24'h0, m});
    evq.push_back(m);
    @(posedge aclk);
    raw <= 8'hFF;
    repeat (4) @(posedge aclk);
    raw <= 8'h00;
    rd(A_FLG, 32'hFF);
    chk_irq("irq", |en, irq);
    wr(A_CLR, 32'hFF);
    repeat (2) @(posedge aclk);
    chk_irq("irq", 1'b0, irq);
    wr(A_FLG, 32'hFF);
    rd(A_FLG, 32'h0);
    // every sense code: one high pulse of the pin, then flag and request
    for (code = 0; code < 8; code++) begin
      wr(A_SNS, code);
      wr(A_NMI, 32'h1);
      @(posedge aclk);
      raw_nmi <= 1'b1;
      repeat (3) @(posedge aclk);
      raw_nmi <= 1'b0;
      repeat (4) @(posedge aclk);
      f = code >= 1 && code <= 5;
      rd(A_NMI, {31'h0, f});
      chk_irq("nmi_irq", f, nmi_irq);
      wr(A_NMI, 32'hFFFFFFFE);
      rd(A_NMI, {31'h0, f});
      // a low-level sense re-sets the flag at once, so its clear is not checked
      if (code != 5) begin
        wr(A_NMI, 32'h1);
        rd(A_NMI, 32'h0);
        chk_irq("nmi_irq", 1'b0, nmi_irq);
      end
    end
    chk("events left", 34'h0, 34'(evq.size()));
    give_verdict();
  end
endmodule
